// ==== common/filter_on_indicator_pkg.sv ====
// Shared constants and types of the windowed averaging filter.
package filter_on_indicator_pkg;

  localparam int DATA_W = 24;
  localparam int STACK_MAX = 100;
  localparam int DEPTH_W = 7;
  localparam int FIFO_DEPTH = 16;
  localparam int FUNC_N = 8;

  localparam logic [6:0] DEPTH_MIN = 7'h01;
  localparam logic [6:0] DEPTH_MAX = 7'h64;
  localparam logic [6:0] DEPTH_DEFAULT = 7'h0a;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [6:0] WIN_DEFAULT_DC = 7'h01;
  localparam logic [6:0] WIN_DEFAULT_AC = 7'h05;
  localparam logic [7:0] PCT_SCALE = 8'h64;

  typedef enum logic [2:0] {
    dc_volts_function = 3'h0,
    ac_volts_function = 3'h1,
    dc_amps_function = 3'h2,
    ac_amps_function = 3'h3,
    ohms_2w_function = 3'h4,
    ohms_4w_function = 3'h5,
    freq_function = 3'h6,
    temp_function = 3'h7
  } func_type;

  typedef enum logic {
    plain_mean_type = 1'b0,
    windowed_mean_type = 1'b1
  } mean_kind_type;

  typedef enum logic [2:0] {
    cmd_plain = 3'h0,
    cmd_windowed = 3'h1,
    cmd_depth = 3'h2,
    cmd_window = 3'h3,
    cmd_mode = 3'h4,
    cmd_auto = 3'h5,
    cmd_toggle = 3'h6,
    cmd_enable = 3'h7
  } cmd_type;

  typedef struct packed {
    logic enable;
    mean_kind_type kind;
    logic repeating;
    logic [6:0] depth;
    logic [6:0] percent_of_range_unit;
  } cfg_type;

  typedef struct packed {
    logic signed [DATA_W-1:0] value;
    logic primary;
    logic db_units;
    logic ratio_delta;
  } sample_type;

  typedef struct packed {
    logic signed [DATA_W-1:0] value;
    logic filtered;
  } reading_type;

  typedef struct packed {
    logic we;
    func_type func;
    cmd_type cmd;
    logic [7:0] value;
  } cfg_write_type;

endpackage : filter_on_indicator_pkg

// ==== hw/sample_fifo.sv ====
// Flop-based FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd_idx;
    logic [AW-1:0] wr_idx;
    logic [CW-1:0] count;
  } fifo_state_type;

  fifo_state_type s_q;
  fifo_state_type s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.count != CW'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data = s_q.mem[s_q.rd_idx];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr_idx] = in_data;
      s_d.wr_idx = (s_q.wr_idx == AW'(DEPTH - 1)) ? '0 : s_q.wr_idx + AW'(1);
    end
    if (pop) begin
      s_d.rd_idx = (s_q.rd_idx == AW'(DEPTH - 1)) ? '0 : s_q.rd_idx + AW'(1);
    end
    if (push && !pop) begin
      s_d.count = s_q.count + CW'(1);
    end else if (pop && !push) begin
      s_d.count = s_q.count - CW'(1);
    end
    if (sys_rst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

endmodule : sample_fifo

// ==== hw/windowed_averaging_filter.sv ====
// Digital averaging filter with optional noise window, moving and repeating modes.
`timescale 1ns/1ns
module windowed_averaging_filter #(
  parameter int DATA_W = filter_on_indicator_pkg::DATA_W,
  parameter int STACK_MAX = filter_on_indicator_pkg::STACK_MAX,
  parameter int FIFO_DEPTH = filter_on_indicator_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire filter_on_indicator_pkg::sample_type in_sample,
  input wire logic in_valid,
  output logic in_ready,
  input wire filter_on_indicator_pkg::func_type active_func,
  input wire logic burst_active,
  input wire logic [DATA_W-1:0] range_full_scale,
  input wire filter_on_indicator_pkg::cfg_write_type cfg_wr,
  output filter_on_indicator_pkg::reading_type out_reading,
  output logic out_valid,
  output logic filter_on_indicator,
  output logic [6:0] stack_fill
);

  localparam int SUM_W = DATA_W + filter_on_indicator_pkg::DEPTH_W;
  localparam int STEP_W = $clog2(SUM_W);
  localparam int CMP_W = DATA_W + 9;
  localparam int SAMPLE_W = $bits(filter_on_indicator_pkg::sample_type);

  typedef enum logic [1:0] {
    st_take = 2'b01,
    st_divide = 2'b10
  } phase_type;

  typedef struct packed {
    phase_type phase;
    filter_on_indicator_pkg::cfg_type [filter_on_indicator_pkg::FUNC_N-1:0] cfg;
    filter_on_indicator_pkg::func_type last_func;
    logic [STACK_MAX-1:0][DATA_W-1:0] stack;
    logic [6:0] wr_idx;
    logic [6:0] count;
    logic signed [SUM_W-1:0] sum;
    logic [SUM_W-1:0] div_quo;
    logic [6:0] div_rem;
    logic [6:0] div_by;
    logic [STEP_W-1:0] div_step;
    logic div_neg;
    logic [DATA_W-1:0] out_value;
    logic out_filtered;
    logic out_valid;
  } filter_on_indicator_state_type;

  // Factory settings of one function; peak turns the filter on for AC volts.
  function automatic filter_on_indicator_pkg::cfg_type auto_cfg(input filter_on_indicator_pkg::func_type f,
                                                 input logic peak);
    filter_on_indicator_pkg::cfg_type c;
    c.enable = 1'b1;
    c.kind = filter_on_indicator_pkg::windowed_mean_type;
    c.repeating = 1'b0;
    c.depth = filter_on_indicator_pkg::DEPTH_DEFAULT;
    c.percent_of_range_unit = filter_on_indicator_pkg::WIN_DEFAULT_DC;
    unique case (f)
      filter_on_indicator_pkg::ac_volts_function: begin
        c.enable = peak;
        c.percent_of_range_unit = filter_on_indicator_pkg::WIN_DEFAULT_AC;
      end
      filter_on_indicator_pkg::ac_amps_function: begin
        c.enable = 1'b0;
        c.percent_of_range_unit = filter_on_indicator_pkg::WIN_DEFAULT_AC;
      end
      filter_on_indicator_pkg::temp_function: begin
        c.kind = filter_on_indicator_pkg::plain_mean_type;
        c.percent_of_range_unit = '0;
      end
      filter_on_indicator_pkg::freq_function: begin
        c = '0;
      end
      default: begin
      end
    endcase
    return c;
  endfunction : auto_cfg

  // Functions on which the windowed type may never be selected.
  function automatic logic window_barred_func(input filter_on_indicator_pkg::func_type f);
    return (f == filter_on_indicator_pkg::temp_function) || (f == filter_on_indicator_pkg::freq_function);
  endfunction : window_barred_func

  // Applies one settings command to the stored configuration of a function.
  function automatic filter_on_indicator_pkg::cfg_type cfg_apply(input filter_on_indicator_pkg::cfg_type c,
                                                  input filter_on_indicator_pkg::cfg_write_type w);
    filter_on_indicator_pkg::cfg_type r;
    r = c;
    unique case (w.cmd)
      filter_on_indicator_pkg::cmd_plain: r.kind = filter_on_indicator_pkg::plain_mean_type;
      filter_on_indicator_pkg::cmd_windowed: begin
        if (!window_barred_func(w.func)) begin
          r.kind = filter_on_indicator_pkg::windowed_mean_type;
        end
      end
      filter_on_indicator_pkg::cmd_depth: begin
        // The depth field is shared by both types, so the kind is not looked at here.
        if (w.value < {1'b0, filter_on_indicator_pkg::DEPTH_MIN}) begin
          r.depth = filter_on_indicator_pkg::DEPTH_MIN;
        end else if (w.value > {1'b0, filter_on_indicator_pkg::DEPTH_MAX}) begin
          r.depth = filter_on_indicator_pkg::DEPTH_MAX;
        end else begin
          r.depth = w.value[6:0];
        end
      end
      filter_on_indicator_pkg::cmd_window: begin
        if (w.value > {1'b0, filter_on_indicator_pkg::PCT_MAX}) begin
          r.percent_of_range_unit = filter_on_indicator_pkg::PCT_MAX;
        end else begin
          r.percent_of_range_unit = w.value[6:0];
        end
      end
      filter_on_indicator_pkg::cmd_mode: r.repeating = w.value[0];
      filter_on_indicator_pkg::cmd_auto: r = auto_cfg(w.func, w.value[0]);
      filter_on_indicator_pkg::cmd_toggle: r.enable = !c.enable;
      filter_on_indicator_pkg::cmd_enable: r.enable = w.value[0];
    endcase
    if (w.func == filter_on_indicator_pkg::freq_function) begin
      r = '0;
    end
    return r;
  endfunction : cfg_apply

  filter_on_indicator_state_type s_q;
  filter_on_indicator_state_type s_d;
  logic [SAMPLE_W-1:0] fifo_data;
  logic fifo_valid;
  logic take_ready;
  filter_on_indicator_pkg::sample_type x;
  filter_on_indicator_pkg::cfg_type cur;
  logic clear;
  logic moving;
  logic window_on;
  logic outside;
  logic [DATA_W-1:0] first;
  logic [DATA_W-1:0] oldest;
  logic signed [DATA_W:0] diff;
  logic [DATA_W:0] abs_diff;
  logic [CMP_W-1:0] lhs;
  logic [CMP_W-1:0] rhs;
  logic signed [SUM_W-1:0] new_sum;
  logic [6:0] new_count;
  logic [7:0] rem_shift;
  logic [SUM_W-1:0] quo_shift;
  logic [SUM_W-1:0] quo_final;

  // Back-pressure: conversions wait in the FIFO while a mean is being divided.
  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) i_sample_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_data(in_sample),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(take_ready)
  );

  assign x = filter_on_indicator_pkg::sample_type'(fifo_data);
  assign cur = s_q.cfg[active_func];
  assign clear = (active_func != s_q.last_func)
                 || (cfg_wr.we && (cfg_wr.func == active_func));
  assign take_ready = (s_q.phase == st_take) && !clear;
  assign moving = !cur.repeating || burst_active;
  assign window_on = (cur.kind == filter_on_indicator_pkg::windowed_mean_type) && !x.db_units
                     && !x.ratio_delta && !window_barred_func(active_func);
  // Oldest entry sits at slot 0 until the ring is full, then at the write slot.
  assign oldest = s_q.stack[s_q.wr_idx];
  assign first = (s_q.count == cur.depth) ? oldest : s_q.stack[0];
  assign diff = $signed({x.value[DATA_W-1], x.value}) - $signed({first[DATA_W-1], first});
  assign abs_diff = diff[DATA_W] ? (DATA_W+1)'(1) + ~diff : diff;
  assign lhs = CMP_W'(abs_diff) * CMP_W'(filter_on_indicator_pkg::PCT_SCALE);
  assign rhs = CMP_W'(range_full_scale) * CMP_W'(cur.percent_of_range_unit);
  assign outside = window_on && (s_q.count != '0) && (lhs > rhs);
  assign rem_shift = {s_q.div_rem, s_q.div_quo[SUM_W-1]};
  assign quo_final = s_q.div_neg ? SUM_W'(0) - quo_shift : quo_shift;

  always_comb begin
    s_d = s_q;
    s_d.out_valid = 1'b0;
    new_sum = s_q.sum;
    new_count = s_q.count;
    quo_shift = {s_q.div_quo[SUM_W-2:0], 1'b0};
    if (cfg_wr.we) begin
      s_d.cfg[cfg_wr.func] = cfg_apply(s_q.cfg[cfg_wr.func], cfg_wr);
    end
    s_d.last_func = active_func;
    if (clear) begin
      s_d.count = '0;
      s_d.sum = '0;
      s_d.wr_idx = '0;
      s_d.phase = st_take;
    end else if (take_ready && fifo_valid) begin
      if (!x.primary || (active_func == filter_on_indicator_pkg::freq_function) || !cur.enable) begin
        s_d.out_value = x.value;
        s_d.out_filtered = 1'b0;
        s_d.out_valid = 1'b1;
      end else if (outside) begin
        // A step outside the window is taken as the new level at once.
        for (int i = 0; i < STACK_MAX; i++) begin
          s_d.stack[i] = x.value;
        end
        s_d.out_value = x.value;
        s_d.out_filtered = 1'b1;
        s_d.out_valid = 1'b1;
        s_d.wr_idx = '0;
        if (moving) begin
          s_d.count = cur.depth;
          s_d.sum = SUM_W'($signed(x.value)) * SUM_W'($signed({1'b0, cur.depth}));
        end else begin
          s_d.count = '0;
          s_d.sum = '0;
        end
      end else begin
        // Same path for both types while the window is not exceeded.
        if (moving && (s_q.count == cur.depth)) begin
          new_sum = s_q.sum + SUM_W'($signed(x.value)) - SUM_W'($signed(oldest));
        end else begin
          new_sum = s_q.sum + SUM_W'($signed(x.value));
          new_count = s_q.count + 7'h01;
        end
        s_d.stack[s_q.wr_idx] = x.value;
        s_d.wr_idx = (s_q.wr_idx >= cur.depth - 7'h01) ? '0 : s_q.wr_idx + 7'h01;
        s_d.sum = new_sum;
        s_d.count = new_count;
        if (new_count >= cur.depth) begin
          s_d.phase = st_divide;
          s_d.div_neg = new_sum[SUM_W-1];
          s_d.div_quo = new_sum[SUM_W-1] ? SUM_W'(0) - new_sum : new_sum;
          s_d.div_rem = '0;
          s_d.div_step = '0;
          s_d.div_by = new_count;
          if (!moving) begin
            s_d.count = '0;
            s_d.sum = '0;
            s_d.wr_idx = '0;
          end
        end
      end
    end else if (s_q.phase == st_divide) begin
      // Restoring division, one quotient bit per cycle; truncates toward zero.
      s_d.div_rem = rem_shift[6:0];
      if (rem_shift >= {1'b0, s_q.div_by}) begin
        s_d.div_rem = 7'(rem_shift - {1'b0, s_q.div_by});
        quo_shift[0] = 1'b1;
      end
      s_d.div_quo = quo_shift;
      s_d.div_step = s_q.div_step + STEP_W'(1);
      if (s_q.div_step == STEP_W'(SUM_W - 1)) begin
        s_d.out_value = quo_final[DATA_W-1:0];
        s_d.out_filtered = 1'b1;
        s_d.out_valid = 1'b1;
        s_d.phase = st_take;
      end
    end
    if (sys_rst) begin
      s_d = '0;
      s_d.phase = st_take;
      s_d.last_func = filter_on_indicator_pkg::dc_volts_function;
      for (int f = 0; f < filter_on_indicator_pkg::FUNC_N; f++) begin
        s_d.cfg[f] = auto_cfg(filter_on_indicator_pkg::func_type'(3'(f)), 1'b0);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  assign out_reading.value = s_q.out_value;
  assign out_reading.filtered = s_q.out_filtered;
  assign out_valid = s_q.out_valid;
  assign filter_on_indicator = cur.enable && (active_func != filter_on_indicator_pkg::freq_function);
  assign stack_fill = s_q.count;

endmodule : windowed_averaging_filter

// ==== verification/windowed_averaging_filter_assertions.sv ====
// Port-level checker of the windowed averaging filter.
`timescale 1ns/1ns
module filter_on_indicator_checker #(
  parameter int STACK_MAX = 100
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_ready,
  input wire filter_on_indicator_pkg::func_type active_func,
  input wire filter_on_indicator_pkg::cfg_write_type cfg_wr,
  input wire filter_on_indicator_pkg::reading_type out_reading,
  input wire logic out_valid,
  input wire logic filter_on_indicator,
  input wire logic [6:0] stack_fill
);
  logic en_bit_q;
  always_ff @(posedge clk_sys) begin
    en_bit_q <= cfg_wr.value[0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  hold_reading_a: assert property (!out_valid |-> $stable(out_reading))
    else $error("Reading changed without a strobe.");
  freq_off_a: assert property (active_func == filter_on_indicator_pkg::freq_function |-> !filter_on_indicator)
    else $error("Indicator lit on the frequency function.");
  filter_on_indicator_src_a: assert property (out_valid && out_reading.filtered |-> $past(filter_on_indicator))
    else $error("Filtered reading while the filter was off.");
  fill_bound_a: assert property (stack_fill <= 7'(STACK_MAX))
    else $error("Stack fill above the depth limit.");
  func_clear_a: assert property (active_func != $past(active_func) |=> stack_fill == 7'h00)
    else $error("Stack kept after a function change.");
  cfg_clear_a: assert property (cfg_wr.we && cfg_wr.func == active_func |=> stack_fill == 7'h00)
    else $error("Stack kept after a configuration write.");
  reset_state_a: assert property ($fell(sys_rst) |-> stack_fill == 7'h00 && !out_valid && in_ready)
    else $error("Wrong state after reset.");
  enable_cmd_a: assert property (cfg_wr.we && cfg_wr.func == active_func &&
    cfg_wr.cmd == filter_on_indicator_pkg::cmd_enable && active_func != filter_on_indicator_pkg::freq_function
    ##1 $stable(active_func) |-> filter_on_indicator == en_bit_q)
    else $error("Enable write not followed.");
  toggle_cmd_a: assert property (cfg_wr.we && cfg_wr.func == active_func &&
    cfg_wr.cmd == filter_on_indicator_pkg::cmd_toggle && active_func != filter_on_indicator_pkg::freq_function
    ##1 $stable(active_func) |-> filter_on_indicator != $past(filter_on_indicator))
    else $error("Toggle write did not flip the filter.");
  auto_on_a: assert property (cfg_wr.we && cfg_wr.func == active_func &&
    cfg_wr.cmd == filter_on_indicator_pkg::cmd_auto && active_func == filter_on_indicator_pkg::dc_volts_function
    ##1 $stable(active_func) |-> filter_on_indicator)
    else $error("Auto did not turn the filter on.");
  cover property (out_valid && out_reading.filtered);
  cover property (out_valid && !out_reading.filtered);
  cover property (!in_ready);
endmodule : filter_on_indicator_checker

bind windowed_averaging_filter filter_on_indicator_checker #(.STACK_MAX(STACK_MAX)) i_filter_on_indicator_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .in_ready(in_ready), .active_func(active_func),
  .cfg_wr(cfg_wr), .out_reading(out_reading), .out_valid(out_valid),
  .filter_on_indicator(filter_on_indicator), .stack_fill(stack_fill)
);

// ==== verification/conv_model.sv ====
// Behavioural model of the converter that offers raw conversions.
`timescale 1ns/1ns
module conv_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_ready,
  output filter_on_indicator_pkg::sample_type in_sample,
  output logic in_valid
);
  filter_on_indicator_pkg::sample_type q[$];
  logic slow = 1'h0;
  task automatic push(input filter_on_indicator_pkg::sample_type s);
    @(negedge clk_sys);
    q.push_back(s);
  endtask : push
  initial begin
    in_valid = 1'h0;
    in_sample = '0;
  end
  // Idle data is inverted every cycle so that nothing stale can pass for a conversion.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      in_valid <= 1'h0;
    end else if (!in_valid || in_ready) begin
      if (q.size() > 0 && !(slow && in_valid)) begin
        in_sample <= q.pop_front();
        in_valid <= 1'h1;
      end else begin
        in_valid <= 1'h0;
        in_sample <= ~in_sample;
      end
    end
  end
endmodule : conv_model

// ==== verification/windowed_averaging_filter_bench.sv ====
// Self-checking bench of the windowed averaging filter.
`timescale 1ns/1ns
module windowed_averaging_filter_bench;
  logic clk_sys;
  logic sys_rst;
  filter_on_indicator_pkg::sample_type in_sample;
  logic in_valid;
  logic in_ready;
  filter_on_indicator_pkg::func_type active_func;
  logic burst_active;
  logic [23:0] range_full_scale;
  filter_on_indicator_pkg::cfg_write_type cfg_wr;
  filter_on_indicator_pkg::reading_type out_reading;
  logic out_valid;
  logic filter_on_indicator;
  logic [6:0] stack_fill;
  int failures;
  int comparisons;

  windowed_averaging_filter i_windowed_averaging_filter (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .in_sample(in_sample), .in_valid(in_valid),
    .in_ready(in_ready), .active_func(active_func), .burst_active(burst_active),
    .range_full_scale(range_full_scale), .cfg_wr(cfg_wr), .out_reading(out_reading),
    .out_valid(out_valid), .filter_on_indicator(filter_on_indicator), .stack_fill(stack_fill)
  );
  conv_model i_conv_model (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .in_ready(in_ready), .in_sample(in_sample),
    .in_valid(in_valid)
  );

  task automatic end_sim;
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic chk_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h got %h", name, exp, got);
    end
  endtask : chk_bit

  // Waits for the next strobe, bounded, and compares the whole reading.
  task automatic chk_out(input logic [23:0] v, input logic f);
    int n = 0;
    @(negedge clk_sys);
    while (out_valid !== 1'h1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 400) begin
      failures++;
      $display("[ERR] out_valid expected 1 got 0");
      end_sim();
    end
    comparisons++;
    if (out_reading !== {v, f}) begin
      failures++;
      $display("[ERR] reading expected %h got %h", {v, f}, out_reading);
    end
  endtask : chk_out

  task automatic send(input logic [23:0] v, input logic [2:0] fl);
    i_conv_model.push({v, fl});
  endtask : send

  task automatic cfg_to(input filter_on_indicator_pkg::func_type f, input filter_on_indicator_pkg::cmd_type c,
                        input logic [7:0] v);
    @(posedge clk_sys);
    cfg_wr <= '{1'h1, f, c, v};
    @(posedge clk_sys);
    cfg_wr.we <= 1'h0;
  endtask : cfg_to

  task automatic cfg(input filter_on_indicator_pkg::cmd_type c, input logic [7:0] v);
    cfg_to(active_func, c, v);
  endtask : cfg

  task automatic setf(input filter_on_indicator_pkg::func_type f);
    @(posedge clk_sys);
    active_func <= f;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : setf

  task automatic t_defaults;
    chk_bit("volts_on", 1'h1, filter_on_indicator);
    setf(filter_on_indicator_pkg::ac_volts_function);
    chk_bit("ac_on", 1'h0, filter_on_indicator);
    setf(filter_on_indicator_pkg::freq_function);
    chk_bit("freq_on", 1'h0, filter_on_indicator);
    setf(filter_on_indicator_pkg::temp_function);
    chk_bit("temp_on", 1'h1, filter_on_indicator);
    cfg_to(filter_on_indicator_pkg::ac_volts_function, filter_on_indicator_pkg::cmd_auto, 8'h01);
    cfg_to(filter_on_indicator_pkg::dc_volts_function, filter_on_indicator_pkg::cmd_enable, 8'h00);
    setf(filter_on_indicator_pkg::ac_volts_function);
    chk_bit("ac_auto", 1'h1, filter_on_indicator);
    setf(filter_on_indicator_pkg::dc_volts_function);
    chk_bit("volts_kept", 1'h0, filter_on_indicator);
    cfg(filter_on_indicator_pkg::cmd_auto, 8'h00);
    @(negedge clk_sys);
    chk_bit("volts_auto", 1'h1, filter_on_indicator);
  endtask : t_defaults

  task automatic t_pass;
    cfg(filter_on_indicator_pkg::cmd_toggle, 8'h00);
    send(24'h00_0123, 3'h4);
    chk_out(24'h00_0123, 1'h0);
    cfg(filter_on_indicator_pkg::cmd_enable, 8'h01);
    send(24'hff_fffb, 3'h0);
    chk_out(24'hff_fffb, 1'h0);
    setf(filter_on_indicator_pkg::freq_function);
    send(24'h00_004d, 3'h4);
    chk_out(24'h00_004d, 1'h0);
    setf(filter_on_indicator_pkg::dc_volts_function);
  endtask : t_pass

  task automatic t_moving;
    cfg(filter_on_indicator_pkg::cmd_plain, 8'h00);
    cfg(filter_on_indicator_pkg::cmd_depth, 8'h02);
    send(24'h00_000a, 3'h4);
    send(24'h00_0014, 3'h4);
    send(24'hff_ffe1, 3'h4);
    chk_out(24'h00_000f, 1'h1);
    chk_out(24'hff_fffb, 1'h1);
  endtask : t_moving

  task automatic t_repeat;
    cfg(filter_on_indicator_pkg::cmd_mode, 8'h01);
    i_conv_model.slow = 1'h1;
    send(24'h00_0004, 3'h4);
    send(24'h00_0008, 3'h4);
    send(24'h00_0064, 3'h4);
    send(24'h00_0066, 3'h4);
    chk_out(24'h00_0006, 1'h1);
    chk_out(24'h00_0065, 1'h1);
    i_conv_model.slow = 1'h0;
    @(posedge clk_sys);
    burst_active <= 1'h1;
    send(24'h00_0001, 3'h4);
    send(24'h00_0003, 3'h4);
    send(24'h00_0005, 3'h4);
    chk_out(24'h00_0002, 1'h1);
    chk_out(24'h00_0004, 1'h1);
    @(posedge clk_sys);
    burst_active <= 1'h0;
    cfg(filter_on_indicator_pkg::cmd_mode, 8'h00);
  endtask : t_repeat

  task automatic t_window;
    cfg(filter_on_indicator_pkg::cmd_windowed, 8'h00);
    cfg(filter_on_indicator_pkg::cmd_window, 8'h01);
    send(24'h00_0064, 3'h4);
    send(24'h00_006c, 3'h4);
    chk_out(24'h00_0068, 1'h1);
    send(24'h00_00c8, 3'h4);
    chk_out(24'h00_00c8, 1'h1);
    send(24'h00_00cc, 3'h4);
    chk_out(24'h00_00ca, 1'h1);
    // Outside around the oldest entry, inside around the newest.
    send(24'h00_00d3, 3'h4);
    chk_out(24'h00_00d3, 1'h1);
    send(24'h00_1388, 3'h6);
    chk_out(24'h00_0a2d, 1'h1);
    cfg(filter_on_indicator_pkg::cmd_window, 8'h00);
    @(negedge clk_sys);
    chk_bit("fill_empty", 1'h1, stack_fill == 7'h00);
    send(24'h00_012c, 3'h4);
    send(24'h00_012c, 3'h4);
    chk_out(24'h00_012c, 1'h1);
    send(24'h00_012d, 3'h4);
    chk_out(24'h00_012d, 1'h1);
  endtask : t_window

  task automatic t_fifo;
    cfg(filter_on_indicator_pkg::cmd_plain, 8'h00);
    cfg(filter_on_indicator_pkg::cmd_depth, 8'h00);
    for (int i = 1; i <= 20; i++) begin
      send(24'(i * 3), 3'h4);
    end
    chk_bit("in_ready", 1'h0, in_ready);
    for (int i = 1; i <= 20; i++) begin
      chk_out(24'(i * 3), 1'h1);
    end
  endtask : t_fifo

  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    failures = 0;
    comparisons = 0;
    sys_rst = 1'h1;
    active_func = filter_on_indicator_pkg::dc_volts_function;
    burst_active = 1'h0;
    range_full_scale = 24'h00_03e8;
    cfg_wr = '0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(negedge clk_sys);
    t_defaults();
    t_pass();
    t_moving();
    t_repeat();
    t_window();
    t_fifo();
    end_sim();
  end
endmodule : windowed_averaging_filter_bench
